//--- cmsc_pkg.sv
package cmsc_pkg;

    // ------------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_ONE   = 4'h0;
    localparam logic [3:0] ADDR_CTRL_TWO   = 4'h1;
    localparam logic [3:0] ADDR_VECTOR     = 4'h2;
    localparam logic [3:0] ADDR_FIFO_CTRL  = 4'h3;
    localparam logic [3:0] ADDR_FIFO_STAT  = 4'h4;
    localparam logic [3:0] ADDR_INT_FLAGS  = 4'h5;
    localparam logic [3:0] ADDR_INT_ENABLE = 4'h6;
    localparam logic [3:0] ADDR_ERR_COUNTS = 4'h7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_HALT_IDLE  = 13;
    localparam int BIT_ABORT_ALL  = 12;
    localparam int POS_MODE_REQ   = 8;
    localparam int POS_MODE_REP   = 5;
    localparam int BIT_CAPTURE    = 3;
    localparam int BIT_WINDOW     = 0;
    localparam int POS_HIT        = 8;
    localparam int POS_DMA_COUNT  = 13;
    localparam int POS_WR_PTR     = 8;
    localparam int BIT_ERROR_FLAG = 5;
    localparam logic [7:0] FLAG_MASK = 8'hef;
    localparam logic [7:0] NON_ERR_FLAGS = 8'hcf;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [6:0] INTERRUPT_CODE_NONE     = 7'h40;
    localparam logic [6:0] INTERRUPT_CODE_ERROR    = 7'h41;
    localparam logic [6:0] INTERRUPT_CODE_WAKE     = 7'h42;
    localparam logic [6:0] INTERRUPT_CODE_OVERFLOW = 7'h43;
    localparam logic [6:0] INTERRUPT_CODE_FIFO     = 7'h44;
    localparam logic [4:0] DATA_COMPARE_BITS_MAX      = 5'h11;
    localparam logic [7:0] WARN_LIMIT     = 8'h60;
    localparam logic [7:0] PASSIVE_LIMIT  = 8'h80;
    localparam int IDLE_BITS = 11;

    typedef enum logic [2:0] {
        CMSC_NORMAL   = 3'b000,
        CMSC_DISABLE  = 3'b001,
        CMSC_LOOPBACK = 3'b010,
        CMSC_LISTEN   = 3'b011,
        CMSC_CONFIG   = 3'b100,
        CMSC_LISTALL  = 3'b111
    } cmsc_mode_t;

    // Protocol engine events, one-cycle pulses
    typedef struct packed {
        logic       rx_done;
        logic [4:0] rx_hit;
        logic [3:0] rx_buf;
        logic       tx_done;
        logic [3:0] tx_buf;
        logic       invalid;
        logic       wake;
        logic       fifo_almost;
        logic       overflow;
        logic       rx_err;
        logic       tx_err;
        logic       rx_ok;
        logic       tx_ok;
        logic       bus_idle_bit;
        logic       recessive;
    } cmsc_event_t;

    // Software register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } cmsc_bus_t;

endpackage

//--- cmsc_ctrl.sv
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// R01: Loopback feeds transmit stream into receive path.
// R02: Loopback releases both bus pins to port.
// R03: Halt-in-idle bit stops module during idle.
// R04: Abort-all clears itself once buffers aborted.
// R05: Software requests mode; reserved codes forbidden.
// R06: Reported mode field, resets to configuration.
// R07: Capture enable pulses capture on reception.
// R08: Window select bit steers register window.
// R09: Data compare bit count, read-only field.
// R10: Report matched filter number of reception.
// R11: Interrupt code shows buffer, error, none.
// R12: Three-bit DMA buffer count field.
// R13: Error-state status bits and combined warning.
// R14: Error flag set from error states.
// R15: Event flags set by hardware, software clears.
// R16: Seven enables share flag bit positions.
// R17: Transmit and receive error counts register.
// R18: Mode change waits for eleven recessive bits; from configuration or disable it switches at once.
// R19: Configuration stops traffic, clears error counts.
// R20: Listen-all keeps partial messages on error.
// R21: Interrupt request is any enabled flag.
// R22: Interrupt code picks one by priority.
module cmsc_ctrl (
    input  wire logic              I_CLK,
    input  wire logic              I_RESETN,
    input  wire cmsc_pkg::cmsc_bus_t   I_BUS,
    output logic [15:0]            O_RDATA,
    input  wire cmsc_pkg::cmsc_event_t I_EVT,
    input  wire logic              I_CPU_IDLE,
    input  wire logic              I_TX_BIT,
    input  wire logic              I_RX_PIN,
    input  wire logic              I_ABORT_DONE,
    input  wire logic [4:0]        I_DATA_COMPARE_BITS,
    input  wire logic [5:0]        I_FIFO_WR,
    input  wire logic [5:0]        I_FIFO_RD,
    output logic                   O_TX_PIN,
    output logic                   O_TX_OE_N,
    output logic                   O_PINS_CAN,
    output logic                   O_RX_BIT,
    output logic                   O_RUN,
    output logic                   O_TX_ALLOW,
    output logic                   O_RX_ALLOW,
    output logic                   O_ABORT_ALL,
    output logic                   O_KEEP_PARTIAL,
    output logic                   O_CAPTURE,
    output logic                   O_WINDOW,
    output logic                   O_IRQ
);
    import cmsc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        halt_in_idle;
        logic        abort_all_tx;
        logic [2:0]  mode_request;
        cmsc_mode_t  mode_report;
        logic        rx_capture_enable;
        logic        window_select;
        logic [4:0]  matched_filter_number;
        logic [6:0]  interrupt_code;
        logic [2:0]  dma_buffer_count;
        logic [4:0]  fifo_start_buffer;
        // Buffer numbers latched; the event pulse is gone when vectored
        logic [3:0]  rx_buf_num;
        logic [3:0]  tx_buf_num;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [7:0]  tx_error_count;
        logic [7:0]  rx_error_count;
        logic [3:0]  idle_run;
        logic [15:0] rdata;
        logic        capture;
        logic        irq;
    } cmsc_state_t;

    cmsc_state_t s_reg;
    cmsc_state_t s_next;

    // Saturating counter step
    function automatic logic [7:0] bump(input logic [7:0] v,
                                         input logic [7:0] d);
        logic [8:0] t;
        t = {1'b0, v} + {1'b0, d};
        bump = t[8] ? 8'hff : t[7:0];
    endfunction

    function automatic logic [7:0] drop(input logic [7:0] v);
        drop = (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction

    logic loop_on;
    logic online;
    logic running;
    logic tx_warn;
    logic rx_warn;
    logic tx_pas;
    logic rx_pas;
    logic tx_off;
    logic [5:0] state_bits;
    logic [7:0] pend;

    // ------------------------------------------------------------------
    // Derived status
    // ------------------------------------------------------------------
    assign running = !(s_reg.halt_in_idle && I_CPU_IDLE);        // R03
    assign loop_on = (s_reg.mode_report == CMSC_LOOPBACK);
    assign online  = (s_reg.mode_report != CMSC_CONFIG) &&
                     (s_reg.mode_report != CMSC_DISABLE);
    assign tx_warn = s_reg.tx_error_count >= WARN_LIMIT;
    assign rx_warn = s_reg.rx_error_count >= WARN_LIMIT;
    assign tx_pas  = s_reg.tx_error_count >= PASSIVE_LIMIT;
    assign rx_pas  = s_reg.rx_error_count >= PASSIVE_LIMIT;
    assign tx_off  = (s_reg.tx_error_count == 8'hff);
    // Status upper byte; combined warning at bit 8
    assign state_bits = {tx_off, tx_pas, rx_pas, tx_warn, rx_warn,
                         tx_warn | rx_warn};                      // R13
    assign pend = s_reg.flags & s_reg.enables & FLAG_MASK;

    // ------------------------------------------------------------------
    // Pin routing; loopback never touches the bus
    // ------------------------------------------------------------------
    assign O_PINS_CAN = online && !loop_on && running;           // R02
    assign O_TX_PIN   = O_PINS_CAN ? I_TX_BIT : 1'b1;
    assign O_TX_OE_N  = !(O_PINS_CAN &&
                          s_reg.mode_report != CMSC_LISTEN);
    assign O_RX_BIT   = loop_on ? I_TX_BIT :                     // R01
                        (O_PINS_CAN ? I_RX_PIN : 1'b1);          // R02
    assign O_RUN      = running && online;
    assign O_TX_ALLOW = O_RUN && (s_reg.mode_report != CMSC_LISTEN)
                        && (s_reg.mode_report != CMSC_LISTALL); // R19
    assign O_RX_ALLOW = O_RUN;                                   // R19
    assign O_KEEP_PARTIAL = (s_reg.mode_report == CMSC_LISTALL); // R20
    assign O_ABORT_ALL = s_reg.abort_all_tx;
    assign O_CAPTURE   = s_reg.capture;
    assign O_WINDOW    = s_reg.window_select;                    // R08
    assign O_IRQ       = s_reg.irq;
    assign O_RDATA     = s_reg.rdata;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] set_f;
        logic [2:0] req;
        s_next = s_reg;
        set_f  = 8'h00;
        req    = s_reg.mode_request;
        s_next.capture = 1'b0;
        s_next.rdata   = 16'h0000;

        // Register writes
        if (I_BUS.wr) begin
            case (I_BUS.addr)
                ADDR_CTRL_ONE: begin
                    s_next.halt_in_idle = I_BUS.wdata[BIT_HALT_IDLE];
                    if (I_BUS.wdata[BIT_ABORT_ALL]) begin
                        s_next.abort_all_tx = 1'b1;              // R04
                    end
                    req = I_BUS.wdata[POS_MODE_REQ +: 3];        // R05
                    s_next.mode_request = req;
                    s_next.rx_capture_enable = I_BUS.wdata[BIT_CAPTURE];
                    s_next.window_select = I_BUS.wdata[BIT_WINDOW];
                end
                ADDR_FIFO_CTRL: begin
                    s_next.dma_buffer_count =
                        I_BUS.wdata[POS_DMA_COUNT +: 3];         // R12
                    s_next.fifo_start_buffer = I_BUS.wdata[4:0];
                end
                ADDR_INT_ENABLE: begin
                    s_next.enables = I_BUS.wdata[7:0] & FLAG_MASK; // R16
                end
                ADDR_INT_FLAGS: begin
                    // Write zero clears, hardware set still wins below
                    s_next.flags = s_reg.flags & I_BUS.wdata[7:0]; // R15
                end
                default: begin
                end
            endcase
        end

        // Abort completes when the buffers report done
        if (s_reg.abort_all_tx && I_ABORT_DONE) begin
            s_next.abort_all_tx = 1'b0;                          // R04
        end

        // Bus idle tracker: eleven recessive bit times
        if (I_EVT.bus_idle_bit) begin
            if (!I_EVT.recessive) begin
                s_next.idle_run = 4'h0;
            end else if (s_reg.idle_run != 4'(IDLE_BITS)) begin
                s_next.idle_run = s_reg.idle_run + 4'h1;
            end
        end

        // Mode switch only when the bus is idle or module off-line
        if (req != s_reg.mode_report &&
            req != 3'b101 && req != 3'b110 &&
            (!online || s_reg.idle_run == 4'(IDLE_BITS))) begin   // R18
            s_next.mode_report = cmsc_mode_t'(req);              // R06
        end

        // Receive and transmit events
        if (running && online) begin
            if (I_EVT.rx_done) begin
                set_f[1] = 1'b1;
                s_next.rx_buf_num = I_EVT.rx_buf;                // R11
                s_next.matched_filter_number = I_EVT.rx_hit;     // R10
                s_next.capture = s_reg.rx_capture_enable;        // R07
            end
            if (I_EVT.tx_done) begin
                set_f[0] = 1'b1;
                s_next.tx_buf_num = I_EVT.tx_buf;                // R11
            end
            set_f[7] = I_EVT.invalid;
            set_f[3] = I_EVT.fifo_almost;
            set_f[2] = I_EVT.overflow;
        end
        set_f[6] = I_EVT.wake && running;                        // R15

        // Error counters; listen modes leave them alone
        if (s_reg.mode_report == CMSC_CONFIG) begin
            s_next.tx_error_count = 8'h00;                       // R19
            s_next.rx_error_count = 8'h00;                       // R19
        end else if (O_TX_ALLOW && s_reg.mode_report != CMSC_LOOPBACK)
        begin
            if (I_EVT.tx_err) begin
                s_next.tx_error_count = bump(s_reg.tx_error_count,
                                             8'h08);             // R17
            end else if (I_EVT.tx_ok) begin
                s_next.tx_error_count = drop(s_reg.tx_error_count);
            end
            if (I_EVT.rx_err) begin
                s_next.rx_error_count = bump(s_reg.rx_error_count,
                                             8'h01);             // R17
            end else if (I_EVT.rx_ok) begin
                s_next.rx_error_count = drop(s_reg.rx_error_count);
            end
        end

        // Error flag follows any error state
        set_f[BIT_ERROR_FLAG] = |state_bits;                     // R14
        s_next.flags = s_next.flags | (set_f & FLAG_MASK);       // R15

        // Vector by fixed priority: error, wake, overflow, fifo, rx, tx
        if (pend[BIT_ERROR_FLAG]) begin
            s_next.interrupt_code = INTERRUPT_CODE_ERROR;                 // R22
        end else if (pend[6]) begin
            s_next.interrupt_code = INTERRUPT_CODE_WAKE;
        end else if (pend[2]) begin
            s_next.interrupt_code = INTERRUPT_CODE_OVERFLOW;
        end else if (pend[3]) begin
            s_next.interrupt_code = INTERRUPT_CODE_FIFO;
        end else if (pend[1]) begin
            s_next.interrupt_code = {3'b000, s_reg.rx_buf_num};  // R11
        end else if (pend[0]) begin
            s_next.interrupt_code = {3'b000, s_reg.tx_buf_num};
        end else begin
            s_next.interrupt_code = INTERRUPT_CODE_NONE;                  // R11
        end
        s_next.irq = |pend;                                      // R21

        // Read data, one cycle later
        if (I_BUS.rd) begin
            case (I_BUS.addr)
                ADDR_CTRL_ONE: s_next.rdata =
                    {2'b00, s_reg.halt_in_idle, s_reg.abort_all_tx,
                     1'b0, s_reg.mode_request, s_reg.mode_report,
                     1'b0, s_reg.rx_capture_enable, 2'b00,
                     s_reg.window_select};                       // R06
                ADDR_CTRL_TWO: s_next.rdata =
                    {11'h000, (I_DATA_COMPARE_BITS > DATA_COMPARE_BITS_MAX) ? DATA_COMPARE_BITS_MAX
                                                    : I_DATA_COMPARE_BITS}; // R09
                ADDR_VECTOR: s_next.rdata =
                    {3'b000, s_reg.matched_filter_number, 1'b0,
                     s_reg.interrupt_code};
                ADDR_FIFO_CTRL: s_next.rdata =
                    {s_reg.dma_buffer_count, 8'h00,
                     s_reg.fifo_start_buffer};
                ADDR_FIFO_STAT: s_next.rdata =
                    {2'b00, I_FIFO_WR, 2'b00, I_FIFO_RD};
                ADDR_INT_FLAGS: s_next.rdata =
                    {2'b00, state_bits, s_reg.flags};            // R13
                ADDR_INT_ENABLE: s_next.rdata = {8'h00, s_reg.enables};
                ADDR_ERR_COUNTS: s_next.rdata =
                    {s_reg.tx_error_count, s_reg.rx_error_count};
                default: s_next.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            s_reg <= '0;
            s_reg.mode_request <= 3'b100;
            s_reg.mode_report  <= CMSC_CONFIG;
            s_reg.interrupt_code <= INTERRUPT_CODE_NONE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_loop_rx;
        @(posedge I_CLK) disable iff (!I_RESETN)
        loop_on |-> (O_RX_BIT == I_TX_BIT && !O_PINS_CAN);
    endproperty
    a_loop_rx: assert property (p_loop_rx) // R01
        else $error("loopback path wrong");

    property p_loop_pins;
        @(posedge I_CLK) disable iff (!I_RESETN)
        loop_on |-> O_TX_OE_N;
    endproperty
    a_loop_pins: assert property (p_loop_pins) // R02
        else $error("pin driven in loopback");

    property p_halt;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (s_reg.halt_in_idle && I_CPU_IDLE) |-> !O_RUN;
    endproperty
    a_halt: assert property (p_halt) // R03
        else $error("running while halted in idle");

    property p_abort;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (O_ABORT_ALL && I_ABORT_DONE) |=> !O_ABORT_ALL;
    endproperty
    a_abort: assert property (p_abort) // R04
        else $error("abort not cleared");

    property p_mode_wait;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (online && s_reg.idle_run != 4'(IDLE_BITS)) |=>
            $stable(s_reg.mode_report);
    endproperty
    a_mode_wait: assert property (p_mode_wait) // R18
        else $error("mode changed on busy bus");

    property p_cfg_clear;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (s_reg.mode_report == CMSC_CONFIG) |->
            (!O_TX_ALLOW && !O_RX_ALLOW) ##1
            (s_reg.tx_error_count == 8'h00 &&
             s_reg.rx_error_count == 8'h00);
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) // R19
        else $error("config mode not quiet");

    property p_capture;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (I_EVT.rx_done && O_RUN && !s_reg.rx_capture_enable) |=>
            !O_CAPTURE;
    endproperty
    a_capture: assert property (p_capture) // R07
        else $error("capture while disabled");

    property p_irq;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (|pend) |=> O_IRQ;
    endproperty
    a_irq: assert property (p_irq) // R21
        else $error("irq missing");

    property p_err_flag;
        @(posedge I_CLK) disable iff (!I_RESETN)
        (|state_bits) |=> s_reg.flags[BIT_ERROR_FLAG];
    endproperty
    a_err_flag: assert property (p_err_flag) // R14
        else $error("error flag not set");

endmodule

//--- cmsc_far_node.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Other nodes on the shared bus, one bit every four module clocks
// ------------------------------------------------------------------
module cmsc_far_node (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_busy,
    output logic      o_bit_tick,
    output logic      o_recessive,
    output logic      o_rx
);
    logic [1:0] phase_reg;
    logic       lvl_reg;

    // Traffic toggles the level so no idle run of 11 bits can build up
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_reg <= 2'h0;
            lvl_reg   <= 1'b1;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h3) begin
                lvl_reg <= i_busy ? ~lvl_reg : 1'b1;
            end
        end
    end

    // Released bus rests recessive through the termination
    assign o_bit_tick  = (phase_reg == 2'h3);
    assign o_recessive = lvl_reg;
    assign o_rx        = lvl_reg;
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    import cmsc_pkg::*;
    logic        I_CLK, I_RESETN, cpu_idle, tx_bit, abort_done, busy;
    logic        tick, rec, rx_pin, rd_seen, tx_pin, tx_oe_n, pins_can;
    logic        rx_bit, run, tx_allow, rx_allow, abort_all, keep_part;
    logic        capture, window, irq;
    logic [4:0]  data_compare_bits;
    logic [5:0]  fwr, frd;
    logic [15:0] rdata, cap_cnt, exp_q[$], msk_q[$];
    logic [31:0] seed, r;
    logic [2:0]  m;
    logic [2:0]  mode_tab[6] = '{3'b000, 3'b001, 3'b010, 3'b011,
                                 3'b111, 3'b100};
    cmsc_bus_t   bus;
    cmsc_event_t evt_b, evt, ev;
    int          failures, total_checks, cycles;

    cmsc_far_node far_u (.i_clk(I_CLK), .i_resetn(I_RESETN), .i_busy(busy),
        .o_bit_tick(tick), .o_recessive(rec), .o_rx(rx_pin));
    cmsc_ctrl dut_u (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_BUS(bus),
        .O_RDATA(rdata), .I_EVT(evt), .I_CPU_IDLE(cpu_idle),
        .I_TX_BIT(tx_bit), .I_RX_PIN(rx_pin), .I_ABORT_DONE(abort_done),
        .I_DATA_COMPARE_BITS(data_compare_bits), .I_FIFO_WR(fwr), .I_FIFO_RD(frd),
        .O_TX_PIN(tx_pin), .O_TX_OE_N(tx_oe_n), .O_PINS_CAN(pins_can),
        .O_RX_BIT(rx_bit), .O_RUN(run), .O_TX_ALLOW(tx_allow),
        .O_RX_ALLOW(rx_allow), .O_ABORT_ALL(abort_all),
        .O_KEEP_PARTIAL(keep_part), .O_CAPTURE(capture), .O_WINDOW(window),
        .O_IRQ(irq));

    // Bus idle bits come from the far node, everything else from here
    always_comb begin
        evt = evt_b;
        evt.bus_idle_bit = tick;
        evt.recessive = rec;
    end

    initial begin
        I_CLK = 1'b0;
        forever #4 I_CLK = ~I_CLK;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t ns: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Strobe low for a cycle after each access, so no double assignment
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge I_CLK);
        bus.wr <= 1'b0;
        @(posedge I_CLK);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e,
                      input logic [15:0] k);
        exp_q.push_back(e & k);
        msk_q.push_back(k);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge I_CLK);
        bus.rd <= 1'b0;
        @(posedge I_CLK);
    endtask

    task automatic pulse(input cmsc_event_t e);
        evt_b <= e;
        @(posedge I_CLK);
        evt_b <= '0;
        @(posedge I_CLK);
    endtask

    // Pins and permissions for a settled mode, with a moving tx stream
    task automatic pin_chk(input logic [2:0] md);
        repeat (4) begin
            r = xs();
            tx_bit <= r[0];
            #1;
            chk(pins_can, md == 3'b000 || md == 3'b011 || md == 3'b111);
            chk(keep_part, md == 3'b111);
            if (md == 3'b010) chk({tx_oe_n, rx_bit}, {1'b1, tx_bit});
            if (md == 3'b000) chk({tx_pin, rx_bit}, {tx_bit, rx_pin});
            if (md == 3'b000) chk(tx_oe_n, 16'h0000);
            if (md == 3'b100) chk({tx_allow, rx_allow}, 16'h0000);
            @(posedge I_CLK);
        end
    endtask

    // Read data is judged the cycle after its strobe, oldest note first
    always @(posedge I_CLK) begin
        rd_seen <= bus.rd;
        if (capture === 1'b1) cap_cnt++;
        if (rd_seen) begin
            chk(rdata & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'd74860;
        {failures, total_checks, cycles, cap_cnt} = '0;
        {I_RESETN, cpu_idle, abort_done, busy} = '0;
        {bus, evt_b, data_compare_bits, fwr, frd} = '0;
        tx_bit = 1'b1;
        repeat (20) @(posedge I_CLK);
        I_RESETN <= 1'b1;
        @(posedge I_CLK);
        rd(ADDR_CTRL_ONE, 16'h0480, 16'hffff);
        rd(ADDR_VECTOR, {9'h000, INTERRUPT_CODE_NONE}, 16'hffff);
        rd(ADDR_INT_ENABLE, 16'h0000, 16'hffff);
        rd(ADDR_ERR_COUNTS, 16'h0000, 16'hffff);
        rd(4'hf, 16'h0000, 16'hffff);
        wr(ADDR_CTRL_ONE, 16'h0500);
        repeat (60) @(posedge I_CLK);
        rd(ADDR_CTRL_ONE, 16'h0080, 16'h00e0);
        for (int i = 0; i < 6; i++) begin
            m = mode_tab[i];
            wr(ADDR_CTRL_ONE, {5'h00, m, 8'h00});
            repeat (60) @(posedge I_CLK);
            rd(ADDR_CTRL_ONE, {5'h00, m, m, 5'h00}, 16'hffff);
            pin_chk(m);
        end
        r = xs();
        data_compare_bits <= 5'(r % 18);
        fwr <= r[13:8];
        frd <= r[5:0];
        rd(ADDR_CTRL_TWO, {11'h000, 5'(r % 18)}, 16'hffff);
        rd(ADDR_FIFO_STAT, {2'b00, r[13:8], 2'b00, r[5:0]}, 16'hffff);
        data_compare_bits <= 5'h1f;
        rd(ADDR_CTRL_TWO, 16'h0011, 16'hffff);
        wr(ADDR_FIFO_CTRL, 16'hc015);
        rd(ADDR_FIFO_CTRL, 16'hc015, 16'hffff);
        wr(ADDR_CTRL_ONE, 16'h0000);
        rd(ADDR_CTRL_ONE, 16'h0000, 16'hffff);
        busy <= 1'b1;
        repeat (12) @(posedge I_CLK);
        wr(ADDR_CTRL_ONE, 16'h0300);
        repeat (60) @(posedge I_CLK);
        rd(ADDR_CTRL_ONE, 16'h0300, 16'hffff);
        busy <= 1'b0;
        repeat (60) @(posedge I_CLK);
        rd(ADDR_CTRL_ONE, 16'h0360, 16'hffff);
        wr(ADDR_CTRL_ONE, 16'h3009);
        repeat (60) @(posedge I_CLK);
        #1;
        chk({window, abort_all}, 16'h0003);
        @(posedge I_CLK);
        cpu_idle <= 1'b1;
        repeat (2) @(posedge I_CLK);
        #1;
        chk(run, 16'h0000);
        @(posedge I_CLK);
        cpu_idle <= 1'b0;
        abort_done <= 1'b1;
        repeat (2) @(posedge I_CLK);
        #1;
        chk({run, abort_all}, 16'h0002);
        @(posedge I_CLK);
        rd(ADDR_CTRL_ONE, 16'h0000, 16'h1000);
        abort_done <= 1'b0;
        ev = '0;
        ev.rx_done = 1'b1;
        ev.rx_hit = 5'h05;
        ev.rx_buf = 4'h3;
        pulse(ev);
        @(posedge I_CLK);
        chk(cap_cnt, 16'h0001);
        wr(ADDR_CTRL_ONE, 16'h0000);
        pulse(ev);
        @(posedge I_CLK);
        chk(cap_cnt, 16'h0001);
        rd(ADDR_INT_FLAGS, 16'h0002, 16'h00ff);
        wr(ADDR_INT_ENABLE, 16'h0002);
        repeat (2) @(posedge I_CLK);
        chk(irq, 16'h0001);
        rd(ADDR_INT_ENABLE, 16'h0002, 16'hffff);
        rd(ADDR_VECTOR, 16'h0503, 16'hffff);
        wr(ADDR_INT_ENABLE, 16'h00ff);
        rd(ADDR_INT_ENABLE, 16'h00ef, 16'hffff);
        ev = '0;
        {ev.invalid, ev.wake, ev.fifo_almost, ev.overflow} = 4'hf;
        ev.tx_done = 1'b1;
        pulse(ev);
        rd(ADDR_INT_FLAGS, 16'h00cf, 16'h00ff);
        rd(ADDR_VECTOR, {9'h000, INTERRUPT_CODE_WAKE}, 16'h007f);
        wr(ADDR_INT_FLAGS, 16'h0000);
        repeat (2) @(posedge I_CLK);
        chk(irq, 16'h0000);
        rd(ADDR_INT_FLAGS, 16'h0000, 16'h00ff);
        rd(ADDR_VECTOR, {9'h000, INTERRUPT_CODE_NONE}, 16'h007f);
        ev = '0;
        ev.tx_err = 1'b1;
        repeat (13) pulse(ev);
        rd(ADDR_ERR_COUNTS, 16'h6800, 16'hffff);
        rd(ADDR_INT_FLAGS, 16'h0520, 16'h3f20);
        wr(ADDR_CTRL_ONE, 16'h0400);
        repeat (60) @(posedge I_CLK);
        rd(ADDR_ERR_COUNTS, 16'h0000, 16'hffff);
        rd(ADDR_INT_FLAGS, 16'h0020, 16'h0020);
        repeat (3) @(posedge I_CLK);
        give_verdict();
    end
endmodule
